/* rtl/i2sp_pkg.sv */
/*
 * Shared constants of the dual audio serial port: word and frame geometry,
 * master bit clock rates and the fractional divider ratios derived from them.
 * Assumes a single 25 MHz system clock.
 */
package i2sp_pkg;

  // system clock
  localparam int unsigned CLK_HZ       = 25_000_000;

  // port count and word geometry
  localparam int unsigned NUM_PORTS    = 2;
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned CNT_W        = 6;

  // master frame formats
  localparam int unsigned FRAME_HZ     = 48_000;
  localparam int unsigned FRAME_BITS_A = 32;
  localparam int unsigned FRAME_BITS_B = 50;
  localparam int unsigned BCLK_A_HZ    = FRAME_HZ * FRAME_BITS_A;
  localparam int unsigned BCLK_B_HZ    = FRAME_HZ * FRAME_BITS_B;

  // highest slave bit clock the far master may use
  localparam int unsigned SLAVE_BCLK_MAX_HZ = 3_072_000;

  // fractional divider: toggle enable rate is 2*bclk = CLK_HZ*N/M
  localparam int unsigned DIV_W        = 16;
  localparam int unsigned DIV_SCALE    = 1000;
  localparam int unsigned DIV_M        = CLK_HZ / DIV_SCALE;
  localparam int unsigned DIV_N_A      = 2 * BCLK_A_HZ / DIV_SCALE;
  localparam int unsigned DIV_N_B      = 2 * BCLK_B_HZ / DIV_SCALE;

  // rate select encoding
  localparam logic        RATE_32      = 1'b0;
  localparam logic        RATE_50      = 1'b1;

  // reset values
  localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
  localparam logic [CNT_W-1:0]     CNT_RST  = 6'h00;

endpackage : i2sp_pkg

/* rtl/i2sp_nm_div.sv */
/*
 * Fractional N over M divider: emits a one-cycle enable at an average rate of
 * clk * N / M. Assumes N < M and both held stable while enabled.
 */
`timescale 1ns/10ps
module i2sp_nm_div #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         en,
  input  wire logic [W-1:0] n,
  input  wire logic [W-1:0] m,
  // enable pulse
  output logic              tick
);

  logic [W:0] acc_r;
  logic [W:0] sum;

  assign sum = acc_r + {1'b0, n};

  // phase accumulator, restarts whenever disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      tick  <= 1'b0;
    end else if (!en) begin
      acc_r <= '0;
      tick  <= 1'b0;
    end else if (sum >= {1'b0, m}) begin
      acc_r <= sum - {1'b0, m};
      tick  <= 1'b1;
    end else begin
      acc_r <= sum;
      tick  <= 1'b0;
    end
  end

endmodule : i2sp_nm_div

/* rtl/i2sp_sync.sv */
/*
 * Two flip-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level relative to the system clock.
 */
`timescale 1ns/10ps
module i2sp_sync #(
  parameter int unsigned W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : i2sp_sync

/* rtl/i2sp_audio_port.sv */
/*
 * Two independent I2S style audio serial ports, each master or slave,
 * 16-bit words, left on word select low, right on word select high.
 * Assumes pins are joined outside from the enables, and that user-side
 * words and mode inputs come from logic on the same clock.
 */
// Behaviour
// - There are two audio serial ports and each one runs independently of the other.
// - Each port is set as master, making bit clock and word select, or as slave taking them.
// - As master the port drives bit clock and word select, as slave it reads them, data out always drives.
// - Each channel word is 16 bits and goes out most significant bit first.
// - The left word's most significant bit follows the frame start by one bit clock as standard I2S.
// - One bit clock after each word select change the next word's top bit appears on a falling edge.
// - The left word goes while word select is low and the right word while it is high.
// - Output data bits change only on the falling edge of bit clock.
// - As master the frame rate is 48 kHz with 32 or 50 bit periods, 1.536 or 2.400 MHz bit clock.
// - As master the bit clock comes from the reference clock through a fractional N over M divider.
`timescale 1ns/10ps
module i2sp_audio_port
  import i2sp_pkg::*;
(
  // clock and reset
  input  wire logic                                clock,
  input  wire logic                                rst,

  // per port mode
  input  wire logic [NUM_PORTS-1:0]                master_en,
  input  wire logic [NUM_PORTS-1:0]                rate_sel,

  // transmit words
  input  wire logic [NUM_PORTS-1:0][WORD_BITS-1:0] tx_left,
  input  wire logic [NUM_PORTS-1:0][WORD_BITS-1:0] tx_right,
  output logic      [NUM_PORTS-1:0]                tx_take,
  output logic      [NUM_PORTS-1:0]                tx_take_right,

  // receive words
  output logic      [NUM_PORTS-1:0][WORD_BITS-1:0] rx_data,
  output logic      [NUM_PORTS-1:0]                rx_valid,
  output logic      [NUM_PORTS-1:0]                rx_right,

  // bit clock pin
  input  wire logic [NUM_PORTS-1:0]                sck_i,
  output logic      [NUM_PORTS-1:0]                sck_o,
  output logic      [NUM_PORTS-1:0]                sck_oe,

  // word select pin
  input  wire logic [NUM_PORTS-1:0]                ws_i,
  output logic      [NUM_PORTS-1:0]                ws_o,
  output logic      [NUM_PORTS-1:0]                ws_oe,

  // data pins
  output logic      [NUM_PORTS-1:0]                sdo,
  input  wire logic [NUM_PORTS-1:0]                sdi
);

  localparam logic [DIV_W-1:0] DIV_M_W   = DIV_W'(DIV_M);
  localparam logic [DIV_W-1:0] DIV_N_A_W = DIV_W'(DIV_N_A);
  localparam logic [DIV_W-1:0] DIV_N_B_W = DIV_W'(DIV_N_B);
  localparam logic [CNT_W-1:0] LAST_A    = CNT_W'(FRAME_BITS_A - 1);
  localparam logic [CNT_W-1:0] LAST_B    = CNT_W'(FRAME_BITS_B - 1);
  localparam logic [CNT_W-1:0] HALF_A    = CNT_W'(FRAME_BITS_A / 2);
  localparam logic [CNT_W-1:0] HALF_B    = CNT_W'(FRAME_BITS_B / 2);
  localparam logic [4:0]       WORD_LEN  = 5'(WORD_BITS);

  // each port is a full copy with no shared state
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port

    logic [DIV_W-1:0] div_n;
    logic             div_tick;
    logic [2:0]       pin_s;
    logic             sck_s;
    logic             ws_s;
    logic             sdi_s;

    logic             sck_r;
    logic             ws_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] half;

    logic             sck_d_r;
    logic             sck_ln;
    logic             ws_ln;
    logic             rise;
    logic             fall;

    logic             ws_smp_r;
    logic             ws_prev_r;
    logic             word_start;

    logic [WORD_BITS-1:0] tx_sh_r;
    logic [4:0]           tx_left_r;
    logic                 sdo_r;

    logic [WORD_BITS-1:0] rx_sh_r;
    logic [4:0]           rx_left_r;
    logic                 rx_chan_r;

    // divider ratio picks 1.536 or 2.400 MHz bit clock
    assign div_n = (rate_sel[p] == RATE_50) ? DIV_N_B_W : DIV_N_A_W;
    assign last  = (rate_sel[p] == RATE_50) ? LAST_B : LAST_A;
    assign half  = (rate_sel[p] == RATE_50) ? HALF_B : HALF_A;

    i2sp_nm_div #(
      .W    (DIV_W)
    ) u_div (
      .clk  (clock),
      .rst  (rst),
      .en   (master_en[p]),
      .n    (div_n),
      .m    (DIV_M_W),
      .tick (div_tick)
    );

    // pins from the far side are asynchronous to us
    i2sp_sync #(
      .W   (3)
    ) u_sync (
      .clk (clock),
      .rst (rst),
      .d   ({sdi[p], ws_i[p], sck_i[p]}),
      .q   (pin_s)
    );

    assign sck_s = pin_s[0];
    assign ws_s  = pin_s[1];
    assign sdi_s = pin_s[2];

    // master bit clock: each divider tick is one half period
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        sck_r <= 1'b0;
      end else if (!master_en[p]) begin
        sck_r <= 1'b0;
      end else if (div_tick) begin
        sck_r <= ~sck_r;
      end
    end

    assign cnt_nxt = (cnt_r >= last) ? CNT_RST : cnt_r + 1'b1;

    // master frame position; word select moves on falling edges
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cnt_r <= CNT_RST;
        ws_r  <= 1'b0;
      end else if (!master_en[p]) begin
        cnt_r <= CNT_RST;
        ws_r  <= 1'b0;
      end else if (div_tick && sck_r) begin
        cnt_r <= cnt_nxt;
        ws_r  <= (cnt_nxt >= half);
      end
    end

    // edge source follows the mode
    assign sck_ln = master_en[p] ? sck_r : sck_s;
    assign ws_ln  = master_en[p] ? ws_r  : ws_s;

    // slave edges come from the second stage only, via one more flop
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        sck_d_r <= 1'b0;
      end else begin
        sck_d_r <= sck_s;
      end
    end

    assign rise = master_en[p] ? (div_tick & ~sck_r) : (sck_s & ~sck_d_r);
    assign fall = master_en[p] ? (div_tick &  sck_r) : (~sck_s & sck_d_r);

    // word select is taken at rising edges, compared at falling edges
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        ws_smp_r <= 1'b0;
      end else if (rise) begin
        ws_smp_r <= ws_ln;
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        ws_prev_r <= 1'b0;
      end else if (fall) begin
        ws_prev_r <= ws_smp_r;
      end
    end

    // change seen one bit after the select edge starts the next word
    assign word_start = fall & (ws_smp_r != ws_prev_r);

    // transmit shifter, updated on falling edges only
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        tx_sh_r   <= WORD_RST;
        tx_left_r <= 5'h00;
        sdo_r     <= 1'b0;
      end else if (word_start) begin
        if (ws_smp_r) begin
          sdo_r   <= tx_right[p][WORD_BITS-1];
          tx_sh_r <= {tx_right[p][WORD_BITS-2:0], 1'b0};
        end else begin
          sdo_r   <= tx_left[p][WORD_BITS-1];
          tx_sh_r <= {tx_left[p][WORD_BITS-2:0], 1'b0};
        end
        tx_left_r <= WORD_LEN - 1'b1;
      end else if (fall) begin
        if (tx_left_r != 5'h00) begin
          sdo_r     <= tx_sh_r[WORD_BITS-1];
          tx_sh_r   <= {tx_sh_r[WORD_BITS-2:0], 1'b0};
          tx_left_r <= tx_left_r - 1'b1;
        end else begin
          sdo_r     <= 1'b0;
        end
      end
    end

    // take pulse comes one cycle after the word is loaded from the user side
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        tx_take[p]       <= 1'b0;
        tx_take_right[p] <= 1'b0;
      end else begin
        tx_take[p]       <= word_start;
        tx_take_right[p] <= word_start ? ws_smp_r : tx_take_right[p];
      end
    end

    // receive: far side shifts on its falling edge, we sample on rising
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        rx_sh_r   <= WORD_RST;
        rx_left_r <= 5'h00;
        rx_chan_r <= 1'b0;
      end else if (word_start) begin
        rx_left_r <= WORD_LEN;
        rx_chan_r <= ws_smp_r;
      end else if (rise && rx_left_r != 5'h00) begin
        rx_sh_r   <= {rx_sh_r[WORD_BITS-2:0], sdi_s};
        rx_left_r <= rx_left_r - 1'b1;
      end
      // rises with no bits left fall through: padding dropped
    end

    // completed word presented with a one-cycle valid
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        rx_data[p]  <= WORD_RST;
        rx_valid[p] <= 1'b0;
        rx_right[p] <= 1'b0;
      end else if (rise && rx_left_r == 5'h01) begin
        rx_data[p]  <= {rx_sh_r[WORD_BITS-2:0], sdi_s};
        rx_valid[p] <= 1'b1;
        rx_right[p] <= rx_chan_r;
      end else begin
        rx_valid[p] <= 1'b0;
      end
    end

    // pin drive: clock and select only as master, data always
    assign sck_o[p]  = sck_r;
    assign sck_oe[p] = master_en[p];
    assign ws_o[p]   = ws_r;
    assign ws_oe[p]  = master_en[p];
    assign sdo[p]    = sdo_r;

  end

endmodule : i2sp_audio_port

/* verif/i2sp_codec_model.sv */
/* Behavioural far-side audio master for a slave port: bit clock, word select, data.
   Assumes the port samples data on rising bit clock edges. */
`timescale 1ns/10ps
module i2sp_codec_model #(
  parameter int HALF = 7
) (
  // clock, reset, next word
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] word,
  // pins and word report
  output logic             sck,
  output logic             ws,
  output logic             sdi,
  output logic             sent,
  output logic             sent_right,
  output logic [15:0]      sent_word
);
  logic [3:0]  div_r;
  logic [4:0]  bit_r;
  logic [15:0] sr_r;
  wire  [4:0]  nb = bit_r + 5'h01;
  // 25 MHz over 2*HALF stays below the slave ceiling
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r      <= 4'h0;
      sck        <= 1'b0;
      ws         <= 1'b0;
      sdi        <= 1'b0;
      sent       <= 1'b0;
      sent_right <= 1'b0;
      sent_word  <= 16'h0000;
      sr_r       <= 16'h0000;
      bit_r      <= 5'h0f; // first fall raises ws: a clean start for the port
    end else begin
      sent  <= 1'b0;
      div_r <= (div_r == 4'(HALF - 1)) ? 4'h0 : div_r + 4'h1;
      if (div_r == 4'(HALF - 1)) begin
        sck <= ~sck;
        if (sck) begin // data moves on falls, read on rises
          bit_r <= nb;
          ws    <= nb[4]; // left half low, right half high
          if (nb[3:0] == 4'h1) begin // msb one bit after ws change
            sdi        <= word[15];
            sr_r       <= {word[14:0], 1'b0};
            sent       <= 1'b1;
            sent_right <= nb[4];
            sent_word  <= word;
          end else begin
            sdi  <= sr_r[15];
            sr_r <= {sr_r[14:0], 1'b0};
          end
        end
      end
    end
  end
endmodule : i2sp_codec_model

/* verif/i2sp_audio_port_chk.sv */
/* Assertion checker for the dual audio port, bound to its top.
   Assumes port 0 is the master under test and port 1 stays slave. */
`timescale 1ns/10ps
module i2sp_audio_port_chk
  import i2sp_pkg::*;
(
  // clock, reset, mode
  input wire logic             clock,
  input wire logic             rst,
  input wire logic [1:0]       master_en,
  input wire logic [1:0]       rate_sel,
  // user and pin side
  input wire logic [1:0][15:0] tx_left,
  input wire logic [1:0][15:0] tx_right,
  input wire logic [1:0]       tx_take,
  input wire logic [1:0]       tx_take_right,
  input wire logic [1:0]       sck_o,
  input wire logic [1:0]       sck_oe,
  input wire logic [1:0]       ws_o,
  input wire logic [1:0]       ws_oe,
  input wire logic [1:0]       sdo
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic       sck_q_r, ws_q_r, seen_r, tseen_r;
  logic [5:0] kcnt_r, rcnt_r;
  logic [3:0] ccnt_r;
  wire m0 = master_en[0];
  wire fl = sck_q_r & ~sck_o[0];
  wire rs = ~sck_q_r & sck_o[0];
  wire wc = ws_q_r ^ ws_o[0];
  // edge history in system clocks; first partial half is not judged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_q_r <= 1'b0;
      ws_q_r  <= 1'b0;
      seen_r  <= 1'b0;
      tseen_r <= 1'b0;
      kcnt_r  <= 6'h00;
      rcnt_r  <= 6'h00;
      ccnt_r  <= 4'h0;
    end else begin
      sck_q_r <= sck_o[0];
      ws_q_r  <= ws_o[0];
      seen_r  <= m0 & (seen_r | wc);
      tseen_r <= m0 & (tseen_r | fl | rs);
      kcnt_r  <= wc ? 6'h00 : kcnt_r + {5'h00, fl};
      rcnt_r  <= wc ? 6'h00 : rcnt_r + {5'h00, rs};
      ccnt_r  <= (fl | rs) ? 4'h1 : ccnt_r + 4'h1;
    end
  end
  a_pin_dir: assert property ({sck_oe, ws_oe} == {master_en, master_en})
    else $error("pin enables do not follow mode");
  a_slave_quiet: assert property (!master_en[1] |-> !sck_o[1])
    else $error("slave port drives bit clock");
  a_slave_ws_low: assert property (!master_en[1] |-> !ws_o[1])
    else $error("slave port drives word select");
  a_sdo_on_fall: assert property (m0 && $past(m0) && $changed(sdo[0]) |-> $fell(sck_o[0]))
    else $error("data changed off a falling edge");
  a_ws_on_fall: assert property (m0 && $changed(ws_o[0]) |-> $fell(sck_o[0]))
    else $error("word select changed off a falling edge");
  a_half_len: assert property (m0 && seen_r && wc |-> rcnt_r == (rate_sel[0] ? 6'h19 : 6'h10))
    else $error("wrong bit count in half frame");
  a_half_per: assert property (m0 && tseen_r && (fl | rs) |->
    (rate_sel[0] ? ccnt_r inside {[4'h5:4'h6]} : ccnt_r inside {[4'h8:4'h9]}))
    else $error("bit clock half period off rate");
  a_msb_first: assert property (tx_take[0] && m0 && seen_r |-> kcnt_r + {5'h00, fl} == 6'h01 &&
    sdo[0] == (tx_take_right[0] ? $past(tx_right[0][15]) : $past(tx_left[0][15])))
    else $error("msb not first bit after ws change");
  a_take_chan: assert property (tx_take[0] && m0 && seen_r |-> tx_take_right[0] == ws_o[0])
    else $error("word channel differs from ws");
  a_tail_low: assert property (m0 && seen_r && kcnt_r > 6'h10 |-> !sdo[0])
    else $error("data high after 16 bits");
  c_right_take: cover property (tx_take[0] && tx_take_right[0]);
  c_half_50: cover property (m0 && seen_r && wc && rate_sel[0]);
  c_tail_50: cover property (m0 && rate_sel[0] && kcnt_r == 6'h18);
endmodule : i2sp_audio_port_chk

bind i2sp_audio_port i2sp_audio_port_chk chk_u (
  .clock, .rst, .master_en, .rate_sel, .tx_left, .tx_right, .tx_take, .tx_take_right,
  .sck_o, .sck_oe, .ws_o, .ws_oe, .sdo
);

/* verif/i2sp_audio_port_tb.sv */
/* Self-checking bench: port 0 master looped back onto itself, port 1 slave
   to a far-side model. Assumes one 25 MHz clock; runs both master rates. */
`timescale 1ns/10ps
module i2sp_audio_port_tb import i2sp_pkg::*;;
  logic             clock = 1'b0;
  logic             rst;
  logic [1:0]       master_en, rate_sel, sck_i, ws_i, sdi;
  logic [1:0][15:0] tx_left, tx_right, rx_data;
  logic [1:0]       tx_take, tx_take_right, rx_valid, rx_right;
  logic [1:0]       sck_o, sck_oe, ws_o, ws_oe, sdo;
  logic             m_sck, m_ws, m_sdi, m_sent, m_right;
  logic [15:0]      m_word, m_sent_word;
  logic [31:0]      seed;
  logic [16:0]      q [2][$];
  int               drop [2];
  int               rxn [2];
  int               bad_count = 0;
  int               comparisons = 0;
  int               cyc = 0;

  always #20 clock = ~clock;
  assign sck_i = {sck_oe[1] ? sck_o[1] : m_sck, sck_o[0]};
  assign ws_i  = {ws_oe[1] ? ws_o[1] : m_ws, ws_o[0]};
  assign sdi   = {m_sdi, sdo[0]}; // port 0 hears its own output

  i2sp_audio_port dut_u (
    .clock, .rst, .master_en, .rate_sel, .tx_left, .tx_right, .tx_take, .tx_take_right,
    .rx_data, .rx_valid, .rx_right, .sck_i, .sck_o, .sck_oe, .ws_i, .ws_o, .ws_oe,
    .sdo, .sdi
  );
  i2sp_codec_model model_u (
    .clock, .rst, .word(m_word), .sck(m_sck), .ws(m_ws), .sdi(m_sdi),
    .sent(m_sent), .sent_right(m_right), .sent_word(m_sent_word)
  );

  function automatic logic [15:0] next_rand();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction : next_rand

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // the word last handed over is the one just received; first two may be partial
  always @(negedge clock) begin
    if (rst) begin
      drop = '{2, 2};
      rxn  = '{0, 0};
      q[0].delete();
      q[1].delete();
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (rx_valid[p] === 1'b1) begin
          rxn[p]++;
          if (drop[p] > 0) drop[p]--;
          else if (q[p].size() > 0) check({rx_right[p], rx_data[p]}, q[p][$]);
        end
        if (tx_take[p] === 1'b1) begin
          if (p == 0) q[0].push_back({tx_take_right[0],
                                      tx_take_right[0] ? tx_right[0] : tx_left[0]});
          if (tx_take_right[p]) tx_right[p] = next_rand();
          else tx_left[p] = next_rand();
        end
      end
      if (m_sent === 1'b1) begin
        q[1].push_back({m_right, m_sent_word});
        m_word = next_rand();
      end
    end
  end

  // two runs take about 12000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    rst       = 1'b1;
    master_en = 2'b01;
    rate_sel  = 2'b00;
    seed      = 32'h0001_6973; // 92531
    tx_left   = {next_rand(), next_rand()};
    tx_right  = {next_rand(), next_rand()};
    m_word    = next_rand();
    for (int r = 0; r < 2; r++) begin
      rst      = 1'b1;
      rate_sel = {2{r[0]}};
      repeat (3) @(negedge clock);
      rst = 1'b0;
      repeat (6000) @(negedge clock);
      check(17'(rxn[0] > 8 && rxn[1] > 8), 17'h0_0001);
    end
    tally_and_finish();
  end
endmodule : i2sp_audio_port_tb
